// [core/fail_output_gpio_alternate.sv]
// Fail-output / alternate-function control of two high-voltage shared pins.
// Assumes the chip mode and failure flag come from the mode controller, pin
// levels are already digital and synchronous, and drivers limit current in analogue.
// Overview of operation
// [RULE1] Reset makes both pins failure outputs
// [RULE2] Wake-configured pins report wake events
// [RULE3] Switches drive statically, no extra diagnosis
// [RULE4] Pin levels shown in normal/stop modes
// [RULE5] Second pin level doubles as strap bit
// [RULE6] Function changes accepted only in normal mode
// [RULE7] Off pins stay inactive outside normal
// [RULE8] Wake pins off only in fail-safe; the code also ignores wake edges in init
// [RULE9] Switches disabled in restart and fail-safe
// [RULE10] Failure outputs activate in restart/fail-safe
// [RULE11] Activation persists into normal mode
// [RULE12] Indicator toggles 1.25 Hz, half duty
// [RULE13] Pulsed output 100 Hz, adjustable duty
// [RULE14] Strap level filtered for 64 us
// [RULE15] External circuit holds strap high
// [RULE16] Duty choices 20/10/5/2.5 percent
// [RULE17] Failure outputs active low, simultaneous
// [RULE18] Waveform counters restart on activation
`timescale 1ns/1ps
`default_nettype none
module fail_output_gpio_alternate
  import fo_gpio_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire fo_gpio_pkg::chip_mode_t mode,
  input  wire logic                    failure,
  input  wire logic                    cfg_write,
  input  wire fo_gpio_pkg::pin_cfg_t   cfg_data,
  input  wire logic                    wake_clear,
  input  wire logic                    ind_pin_level,
  input  wire logic                    pulse_pin_level,
  output logic                         indicator_fail_output,
  output logic                         pulsed_fail_output_strap_pin,
  output fo_gpio_pkg::pin_drive_t      ind_drive,
  output fo_gpio_pkg::pin_drive_t      pulse_drive,
  output fo_gpio_pkg::pin_cfg_t        cfg,
  output logic [1:0]                   second_wake_status,
  output logic [1:0]                   wake_level_status,
  output logic                         second_alternate_pin_level,
  output logic                         dev_strap
);
  import fo_gpio_pkg::*;

  localparam int IND_W   = $clog2(IND_PERIOD_CYC);
  localparam int PULSE_W = $clog2(PULSE_PERIOD_CYC);
  localparam int STRAP_W = $clog2(STRAP_FILTER_CYC + 1);

  // Pulsed-light high-time lookup per duty setting
  function automatic logic [PULSE_W-1:0] duty_cycles(input logic [1:0] sel);
    case (sel)
      DUTY_10:  duty_cycles = PULSE_W'(PULSE_PERIOD_CYC / 10);
      DUTY_5:   duty_cycles = PULSE_W'(PULSE_PERIOD_CYC / 20);
      DUTY_2P5: duty_cycles = PULSE_W'(PULSE_PERIOD_CYC / 40);
      default:  duty_cycles = PULSE_W'(PULSE_PERIOD_CYC / 5); // RULE16
    endcase
  endfunction

  // Per-pin drive decoding by function, mode and fail activity
  function automatic pin_drive_t decode_drive(input pin_fn_t fn, input chip_mode_t m,
                                              input logic fo_on, input logic wave);
    logic run;
    run = (m == MODE_NORMAL) || (m == MODE_STOP) || (m == MODE_SLEEP);
    decode_drive = '{low_on: 1'b0, high_on: 1'b0};
    case (fn)
      FN_FAIL_OUT:  decode_drive.low_on = fo_on & wave;           // RULE17
      FN_LOW_SIDE:  decode_drive.low_on = run;                    // RULE9
      FN_HIGH_SIDE: decode_drive.high_on = run;                   // RULE3
      default:      decode_drive = '{low_on: 1'b0, high_on: 1'b0}; // RULE7
    endcase
  endfunction

  logic               fo_active, next_fo_active;
  logic [IND_W-1:0]   ind_cnt, next_ind_cnt;
  logic [PULSE_W-1:0] pulse_cnt, next_pulse_cnt;
  pin_cfg_t           next_cfg;
  logic [1:0]         level_q, next_level_q;
  logic [1:0]         wake_prev, next_wake_prev;
  logic [1:0]         next_wake_status, next_level_status;
  logic [STRAP_W-1:0] strap_cnt, next_strap_cnt;
  logic               strap_raw, next_strap_raw;
  logic               next_dev_strap, next_strap_bit;
  logic               ind_wave, pulse_wave;
  pin_drive_t         next_ind_drive, next_pulse_drive;
  logic               next_ind_fo, next_pulse_fo;
  logic               wake_ok;

  // Configuration register, writable in normal mode only
  always_comb begin
    next_cfg = cfg;
    if (cfg_write && mode == MODE_NORMAL) begin // RULE6
      next_cfg = cfg_data;                      // RULE16
    end
  end

  // Fail activation latch
  always_comb begin
    next_fo_active = fo_active;
    if ((mode == MODE_RESTART || mode == MODE_FAIL_SAFE) && failure) begin
      next_fo_active = 1'b1; // RULE10
    end else if (!failure && mode == MODE_NORMAL) begin
      next_fo_active = 1'b0; // RULE11
    end
  end

  // Waveform counters, restarted on activation
  always_comb begin
    if (!fo_active) begin
      next_ind_cnt   = '0; // RULE18
      next_pulse_cnt = '0;
    end else begin
      next_ind_cnt   = (ind_cnt == IND_W'(IND_PERIOD_CYC - 1)) ? '0 : ind_cnt + 1'b1;       // RULE12
      next_pulse_cnt = (pulse_cnt == PULSE_W'(PULSE_PERIOD_CYC - 1)) ? '0 : pulse_cnt + 1'b1; // RULE13
    end
    ind_wave   = ind_cnt < IND_W'(IND_HALF_CYC);
    pulse_wave = pulse_cnt < duty_cycles(cfg.duty);
  end

  // Pin drives and active-low fail outputs
  always_comb begin
    next_ind_drive   = decode_drive(cfg.fn_ind, mode, next_fo_active, ind_wave);
    next_pulse_drive = decode_drive(cfg.fn_pulse, mode, next_fo_active, pulse_wave);
    next_ind_fo      = ~next_ind_drive.low_on;   // RULE17
    next_pulse_fo    = ~next_pulse_drive.low_on; // RULE17
  end

  // Wake detection and level reporting
  always_comb begin
    wake_ok = mode != MODE_FAIL_SAFE && mode != MODE_INIT; // RULE8
    next_level_q   = {pulse_pin_level, ind_pin_level};
    next_wake_prev = level_q;
    next_wake_status = wake_clear ? 2'h0 : second_wake_status;
    if (wake_ok && cfg.fn_ind == FN_WAKE && level_q[0] != wake_prev[0]) begin
      next_wake_status[0] = 1'b1; // RULE2
    end
    if (wake_ok && cfg.fn_pulse == FN_WAKE && level_q[1] != wake_prev[1]) begin
      next_wake_status[1] = 1'b1; // RULE2
    end
    next_level_status = wake_level_status;
    if (mode == MODE_NORMAL || mode == MODE_STOP) begin
      next_level_status = level_q; // RULE4
    end
  end

  // Strap filter: level must be stable for the filter time
  always_comb begin
    next_strap_raw = pulse_pin_level;
    next_strap_cnt = strap_cnt;
    next_dev_strap = dev_strap;
    if (strap_raw != dev_strap) begin
      if (strap_cnt == STRAP_W'(STRAP_FILTER_CYC - 1)) begin
        next_dev_strap = strap_raw; // RULE14
        next_strap_cnt = '0;
      end else begin
        next_strap_cnt = strap_cnt + 1'b1;
      end
    end else begin
      next_strap_cnt = '0;
    end
    // Level bit shared with strap report
    next_strap_bit = (mode == MODE_INIT) ? next_dev_strap : next_level_status[1]; // RULE5
  end

  // Configuration register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg <= CFG_RESET; // RULE1
    end else begin
      cfg <= next_cfg;
    end
  end

  // Fail activation latch
  always_ff @(posedge clk) begin
    if (!rstn) begin
      fo_active <= 1'b0;
    end else begin
      fo_active <= next_fo_active;
    end
  end

  // Waveform counters
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ind_cnt   <= '0;
      pulse_cnt <= '0;
    end else begin
      ind_cnt   <= next_ind_cnt;
      pulse_cnt <= next_pulse_cnt;
    end
  end

  // Pin drives and fail outputs, released while in reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ind_drive                    <= '0;
      pulse_drive                  <= '0;
      indicator_fail_output        <= 1'b1;
      pulsed_fail_output_strap_pin <= 1'b1;
    end else begin
      ind_drive                    <= next_ind_drive;
      pulse_drive                  <= next_pulse_drive;
      indicator_fail_output        <= next_ind_fo;
      pulsed_fail_output_strap_pin <= next_pulse_fo;
    end
  end

  // Wake and level state; edge history seeded from the pins, so no false edge after reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      level_q            <= {pulse_pin_level, ind_pin_level};
      wake_prev          <= {pulse_pin_level, ind_pin_level};
      second_wake_status <= 2'h0;
      wake_level_status  <= 2'h0;
    end else begin
      level_q            <= next_level_q;
      wake_prev          <= next_wake_prev;
      second_wake_status <= next_wake_status;
      wake_level_status  <= next_level_status;
    end
  end

  // Strap filter, starting from the high level the board must hold
  always_ff @(posedge clk) begin
    if (!rstn) begin
      strap_raw                  <= 1'b1; // RULE15
      strap_cnt                  <= '0;
      dev_strap                  <= 1'b1;
      second_alternate_pin_level <= 1'b1;
    end else begin
      strap_raw                  <= next_strap_raw;
      strap_cnt                  <= next_strap_cnt;
      dev_strap                  <= next_dev_strap;
      second_alternate_pin_level <= next_strap_bit;
    end
  end

endmodule
`default_nettype wire

// [core/fo_gpio_pkg.sv]
// Package for the shared fail-output / alternate-function pin block.
// Assumes a 100 MHz core clock and a chip mode supplied by the mode controller.
package fo_gpio_pkg;

  // Pin function selection, per pin
  typedef enum logic [2:0] {
    FN_FAIL_OUT,
    FN_OFF,
    FN_WAKE,
    FN_LOW_SIDE,
    FN_HIGH_SIDE
  } pin_fn_t;

  // Chip operating modes
  typedef enum logic [2:0] {
    MODE_INIT,
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP,
    MODE_RESTART,
    MODE_FAIL_SAFE
  } chip_mode_t;

  // Pulsed-light duty selection
  localparam logic [1:0] DUTY_20  = 2'h0;
  localparam logic [1:0] DUTY_10  = 2'h1;
  localparam logic [1:0] DUTY_5   = 2'h2;
  localparam logic [1:0] DUTY_2P5 = 2'h3;
  localparam logic [1:0] DUTY_RESET = DUTY_20;

  // Timing
  localparam int CLK_HZ          = 100_000_000;
  localparam int IND_FREQ_MHZ    = 1250;            // 1.25 Hz in milli-hertz
  localparam int PULSE_FREQ_HZ   = 100;
  localparam int STRAP_FILTER_US = 64;
  localparam int IND_PERIOD_CYC  = (CLK_HZ / IND_FREQ_MHZ) * 1000;
  localparam int IND_HALF_CYC    = IND_PERIOD_CYC / 2;
  localparam int PULSE_PERIOD_CYC = CLK_HZ / PULSE_FREQ_HZ;
  localparam int STRAP_FILTER_CYC = (CLK_HZ / 1_000_000) * STRAP_FILTER_US;

  // Configuration of both pins together
  typedef struct packed {
    pin_fn_t    fn_ind;    // Function of indicator pin
    pin_fn_t    fn_pulse;  // Function of pulsed/strap pin
    logic [1:0] duty;
  } pin_cfg_t;

  localparam pin_cfg_t CFG_RESET = '{fn_ind: FN_FAIL_OUT, fn_pulse: FN_FAIL_OUT, duty: DUTY_RESET};

  // Pin driver controls, per pin
  typedef struct packed {
    logic low_on;   // Low-side driver enable (also active-low fail drive)
    logic high_on;  // High-side driver enable
  } pin_drive_t;

endpackage

// [bench/fo_gpio_checker.sv]
// Assertions on the shared fail-output pin block.
// Bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module fo_gpio_checker
  import fo_gpio_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    rstn,
  input wire fo_gpio_pkg::chip_mode_t mode,
  input wire logic                    failure,
  input wire logic                    cfg_write,
  input wire fo_gpio_pkg::pin_cfg_t   cfg_data,
  input wire logic                    wake_clear,
  input wire logic                    ind_pin_level,
  input wire logic                    pulse_pin_level,
  input wire logic                    indicator_fail_output,
  input wire logic                    pulsed_fail_output_strap_pin,
  input wire fo_gpio_pkg::pin_drive_t ind_drive,
  input wire fo_gpio_pkg::pin_drive_t pulse_drive,
  input wire fo_gpio_pkg::pin_cfg_t   cfg,
  input wire logic [1:0]              second_wake_status,
  input wire logic [1:0]              wake_level_status,
  input wire logic                    dev_strap
);
  import fo_gpio_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [13:0] same_cnt;
  logic        last_lvl;
  // Cycles the strap level has stayed put
  always_ff @(posedge clk) begin
    if (!rstn) begin
      last_lvl <= pulse_pin_level;
      same_cnt <= 14'h0;
    end else begin
      last_lvl <= pulse_pin_level;
      same_cnt <= (pulse_pin_level != last_lvl) ? 14'h0 : ((&same_cnt) ? same_cnt : same_cnt + 14'h1);
    end
  end
  cfg_take_a: assert property (cfg_write && mode == MODE_NORMAL |=> cfg == $past(cfg_data))
    else $error("config write lost");
  cfg_hold_a: assert property (!(cfg_write && mode == MODE_NORMAL) |=> $stable(cfg))
    else $error("config changed outside a normal write");
  sw_off_a: assert property (
    mode == MODE_RESTART || mode == MODE_FAIL_SAFE |=> !ind_drive.high_on && !pulse_drive.high_on)
    else $error("high side on in restart or fail-safe");
  off_quiet_a: assert property ((cfg.fn_ind == FN_OFF)[*2] |-> ind_drive == 2'h0)
    else $error("off pin driven");
  fail_act_a: assert property (
    $rose(failure) && mode == MODE_RESTART && cfg.fn_ind == FN_FAIL_OUT |-> ##[1:2] !indicator_fail_output)
    else $error("indicator not activated");
  fail_sync_a: assert property (
    $fell(indicator_fail_output) && cfg.fn_ind == FN_FAIL_OUT && cfg.fn_pulse == FN_FAIL_OUT
    |-> $fell(pulsed_fail_output_strap_pin))
    else $error("fail outputs not simultaneous");
  wake_set_a: assert property (
    cfg.fn_ind == FN_WAKE && mode == MODE_SLEEP && $changed(ind_pin_level) |-> ##[1:3] second_wake_status[0])
    else $error("wake event not recorded");
  wake_keep_a: assert property (second_wake_status[0] && !wake_clear |=> second_wake_status[0])
    else $error("wake flag lost");
  level_show_a: assert property ((mode == MODE_NORMAL && ind_pin_level)[*3] |=> wake_level_status[0])
    else $error("pin level not shown");
  strap_filt_a: assert property ($changed(dev_strap) |-> same_cnt >= 14'h1900)
    else $error("strap changed before filter time");
endmodule
bind fail_output_gpio_alternate fo_gpio_checker i_fo_gpio_checker (.clk(clk), .rstn(rstn), .mode(mode),
  .failure(failure), .cfg_write(cfg_write), .cfg_data(cfg_data), .wake_clear(wake_clear),
  .ind_pin_level(ind_pin_level), .pulse_pin_level(pulse_pin_level), .indicator_fail_output(indicator_fail_output),
  .pulsed_fail_output_strap_pin(pulsed_fail_output_strap_pin), .ind_drive(ind_drive), .pulse_drive(pulse_drive),
  .cfg(cfg), .second_wake_status(second_wake_status), .wake_level_status(wake_level_status), .dev_strap(dev_strap));
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench for the shared fail-output pin block.
// Drives every port itself; one 100 MHz clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fo_gpio_pkg::*;
  logic       clk = 0, rstn = 0, failure = 0, cfg_write = 0, wake_clear = 0, ind_pin_level = 0;
  // Strap pin held high through power-up and reset
  logic       pulse_pin_level = 1;
  chip_mode_t mode = MODE_INIT;
  pin_cfg_t   cfg_data = CFG_RESET, cfg;
  pin_drive_t ind_drive, pulse_drive;
  logic [1:0] second_wake_status, wake_level_status;
  logic       ifo, pfo, dev_strap, lvl2;
  int         errors = 0, checked = 0;
  localparam pin_cfg_t SW = '{fn_ind: FN_LOW_SIDE, fn_pulse: FN_HIGH_SIDE, duty: DUTY_10};
  localparam pin_cfg_t OFF = '{fn_ind: FN_OFF, fn_pulse: FN_OFF, duty: DUTY_5};
  localparam pin_cfg_t WK = '{fn_ind: FN_WAKE, fn_pulse: FN_WAKE, duty: DUTY_20};
  localparam pin_cfg_t DC = '{fn_ind: FN_FAIL_OUT, fn_pulse: FN_FAIL_OUT, duty: DUTY_2P5};
  always #5 clk = ~clk;
  fail_output_gpio_alternate i_fail_output_gpio_alternate (.clk(clk), .rstn(rstn), .mode(mode),
    .failure(failure), .cfg_write(cfg_write), .cfg_data(cfg_data), .wake_clear(wake_clear),
    .ind_pin_level(ind_pin_level), .pulse_pin_level(pulse_pin_level), .indicator_fail_output(ifo),
    .pulsed_fail_output_strap_pin(pfo), .ind_drive(ind_drive), .pulse_drive(pulse_drive), .cfg(cfg),
    .second_wake_status(second_wake_status), .wake_level_status(wake_level_status),
    .second_alternate_pin_level(lvl2), .dev_strap(dev_strap));
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic go(input chip_mode_t m, input int n);
    @(posedge clk) mode <= m;
    cyc(n);
  endtask
  task automatic wr(input pin_cfg_t d);
    @(posedge clk);
    cfg_data  <= d;
    cfg_write <= 1'b1;
    @(posedge clk) cfg_write <= 1'b0;
  endtask
  task automatic clr;
    @(posedge clk) wake_clear <= 1'b1;
    @(posedge clk) wake_clear <= 1'b0;
  endtask
  task automatic do_reset;
    @(posedge clk) rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    cyc(1);
  endtask
  task automatic t_strap;
    chk(cfg === CFG_RESET && ifo === 1'b1 && pfo === 1'b1 && ind_drive === 2'h0, "reset state");
    @(posedge clk) pulse_pin_level <= 1'b0;
    cyc(6000);
    chk(dev_strap === 1'b1, "strap changed early");
    chk(lvl2 === 1'b1, "strap bit changed early");
    cyc(500);
    chk(dev_strap === 1'b0, "strap not taken");
    chk(lvl2 === 1'b0, "strap bit not shown");
    @(posedge clk) pulse_pin_level <= 1'b1;
  endtask
  task automatic t_cfg;
    go(MODE_STOP, 1);
    wr(SW);
    cyc(1);
    chk(cfg === CFG_RESET, "write taken outside normal");
    go(MODE_NORMAL, 1);
    wr(SW);
    cyc(2);
    chk(cfg === SW && ind_drive.low_on === 1'b1 && pulse_drive.high_on === 1'b1, "switch drive");
    go(MODE_SLEEP, 2);
    chk(ind_drive.low_on === 1'b1 && pulse_drive.high_on === 1'b1, "switch not held");
    go(MODE_RESTART, 2);
    chk(ind_drive === 2'h0 && pulse_drive === 2'h0 && cfg === SW, "switch not off");
    go(MODE_NORMAL, 2);
    chk(ind_drive.low_on === 1'b1 && pulse_drive.high_on === 1'b1, "switch not resumed");
    wr(OFF);
    go(MODE_STOP, 2);
    chk(ind_drive === 2'h0 && pulse_drive === 2'h0 && ifo === 1'b1, "off pin active");
  endtask
  task automatic t_wake;
    go(MODE_NORMAL, 1);
    wr(WK);
    @(posedge clk) ind_pin_level <= 1'b1;
    cyc(4);
    chk(wake_level_status[0] === 1'b1, "level not shown");
    clr;
    go(MODE_SLEEP, 1);
    @(posedge clk) ind_pin_level <= 1'b0;
    cyc(4);
    chk(second_wake_status === 2'h1, "no wake in sleep");
    go(MODE_FAIL_SAFE, 1);
    @(posedge clk) pulse_pin_level <= 1'b0;
    cyc(4);
    chk(second_wake_status[1] === 1'b0, "wake in fail-safe");
    chk(wake_level_status[1] === 1'b1 && lvl2 === 1'b1, "level updated in fail-safe");
    go(MODE_RESTART, 1);
    @(posedge clk) pulse_pin_level <= 1'b1;
    cyc(4);
    chk(second_wake_status === 2'h3 && cfg === WK, "no wake in restart");
  endtask
  task automatic t_fail;
    do_reset;
    go(MODE_NORMAL, 1);
    wr(DC);
    go(MODE_RESTART, 1);
    @(posedge clk) failure <= 1'b1;
    cyc(3);
    chk(ifo === 1'b0 && pfo === 1'b0, "fail outputs idle");
    go(MODE_NORMAL, 3);
    chk(ifo === 1'b0 && cfg === DC, "activation lost in normal");
    cyc(24993);
    chk(pfo === 1'b0, "pulse ended early");
    cyc(3);
    chk(pfo === 1'b1, "pulse too long");
    chk(ifo === 1'b0, "indicator left half period");
    @(posedge clk) failure <= 1'b0;
    cyc(3);
    chk(ifo === 1'b1 && pfo === 1'b1, "fail outputs stuck");
  endtask
  task automatic stop_test;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    do_reset;
    t_strap;
    t_cfg;
    t_wake;
    t_fail;
    stop_test;
  end
  // Watchdog against a hang
  initial begin
    #400_000;
    errors++;
    $display("mismatch at %0t: timeout", $time);
    stop_test;
  end
endmodule
`default_nettype wire
